// *** ccrs_map.vh ***
// Purpose: shared constants of the codec clock and reset sequencer
// Assumes: included by every design file of the sequencer
// Notes: counts are in master clock cycles or sample periods
`ifndef CCRS_MAP_VH
`define CCRS_MAP_VH

// ----------------------------------------
// sequencing counts
// ----------------------------------------
`define CCRS_RELEASE_CYC 11'h400
`define CCRS_DAC_DLY 12'h834
`define CCRS_ADC_DLY 13'h1194

// ----------------------------------------
// clock relations
// ----------------------------------------
`define CCRS_BPF_A 7'h40
`define CCRS_BPF_B 7'h30
`define CCRS_RATIO_TOL 11'h002
`define CCRS_CNT_MAX 11'h7FF

// ----------------------------------------
// data path
// ----------------------------------------
`define CCRS_MID_LEVEL 3'h4
`define CCRS_OS_HALF 7'h20
`define CCRS_HPF_SHIFT 4'hA
`define CCRS_INTERP_SHIFT 4'h3
`define CCRS_GAIN_SHIFT 11

`endif

// *** ccrs_fade.v ***
// Purpose: fade gain ramp, one step per sample period
// Assumes: tick is a one-cycle pulse per frame
// Notes: direction may change at any step
`timescale 1ns/1ps
`default_nettype none
`include "ccrs_map.vh"

module ccrs_fade (
  input wire core_clk,
  input wire sys_rst,
  input wire clear,
  input wire up,
  input wire tick,
  output reg [11:0] level,
  output wire at_top,
  output wire at_zero
);

  assign at_top = (level == `CCRS_DAC_DLY);
  assign at_zero = (level == 12'h000);

  // direction is sampled on every step, so a reversal takes effect at
  // the very next sample period instead of after the ramp ends
  always @(posedge core_clk) begin
    if (sys_rst || clear) begin
      level <= 12'h000;
    end else if (tick) begin
      if (up && !at_top) begin // R13
        level <= level + 12'h001;
      end else if (!up && !at_zero) begin // R13
        level <= level - 12'h001;
      end
    end
  end

endmodule
`default_nettype wire

// *** ccrs_ratio_detect.v ***
// Purpose: master clock to frame clock ratio detection
// Assumes: edge pulses come from synchronised pins on core_clk
// Notes: master clock must stay below a quarter of core_clk
`timescale 1ns/1ps
`default_nettype none
`include "ccrs_map.vh"

module ccrs_ratio_detect (
  input wire core_clk,
  input wire sys_rst,
  input wire mclk_rise,
  input wire bclk_rise,
  input wire frame_rise,
  output reg in_sync,
  output reg ratio_low,
  output reg [3:0] os_div
);

  reg [10:0] mcount;
  reg [6:0] bcount;
  reg [4:0] last_code;
  wire [4:0] code;
  wire bpf_ok;

  function near;
    input [10:0] n;
    input [10:0] r;
    begin
      near = (n + `CCRS_RATIO_TOL >= r) && (n <= r + `CCRS_RATIO_TOL);
    end
  endfunction

  // code: {valid, master cycles per 64fs tick}
  function [4:0] classify;
    input [10:0] n;
    begin
      if (near(n, 11'h080)) classify = 5'h12;
      else if (near(n, 11'h0C0)) classify = 5'h13;
      else if (near(n, 11'h100)) classify = 5'h14;
      else if (near(n, 11'h180)) classify = 5'h16;
      else if (near(n, 11'h200)) classify = 5'h18;
      else if (near(n, 11'h300)) classify = 5'h1C;
      else classify = 5'h00;
    end
  endfunction

  assign code = classify(mcount); // R1 R20
  assign bpf_ok = (bcount == `CCRS_BPF_A) || (bcount == `CCRS_BPF_B);

  always @(posedge core_clk) begin
    if (sys_rst) begin
      mcount <= 11'h000;
      bcount <= 7'h00;
      last_code <= 5'h00;
      in_sync <= 1'b0;
      ratio_low <= 1'b0;
      os_div <= 4'h4;
    end else if (frame_rise) begin
      mcount <= {10'h000, mclk_rise};
      bcount <= {6'h00, bclk_rise};
      last_code <= code;
      // a frame whose count disagrees drops lock at once; two equal
      // frames in a row are needed to regain it
      if (code[4] && bpf_ok && code == last_code) begin // R20 R18
        in_sync <= 1'b1;
        os_div <= code[3:0];
        ratio_low <= (code[3:0] < 4'h4); // R3
      end else begin
        in_sync <= 1'b0; // R18
      end
    end else begin
      if (mclk_rise && mcount != `CCRS_CNT_MAX) begin
        mcount <= mcount + 11'h001;
      end
      if (bclk_rise && bcount != 7'h7F) begin
        bcount <= bcount + 7'h01;
      end
      // a missing frame edge also counts as loss of lock
      if (mcount == `CCRS_CNT_MAX) begin
        in_sync <= 1'b0; // R18
      end
    end
  end

endmodule
`default_nettype wire

// *** ccrs_sequencer.v ***
// Purpose: reset, power-down and fade sequencing with converter paths
// Assumes: all pins arrive asynchronously to core_clk
// Notes: sys_rst stands for the power-on reset circuit
`timescale 1ns/1ps
`default_nettype none
`include "ccrs_map.vh"

// Overview of operation
// R1 - detect master clock ratio 128..768 fs automatically, 16 to 192 kHz
// R2 - 192 kHz rate served by playback path only
// R3 - at 128 or 192 fs record path off, serial output low
// R4 - internal reset held 1024 master cycles after power-on reset ends
// R5 - once synced, playback fades in and follows input after 2100 samples
// R6 - record output carries data only after 4500 sample periods
// R7 - without clock sync internal reset stays asserted, power-down kept
// R8 - on resync playback fades in, record resumes after initialisation
// R9 - power-down pin low forces reset and lowest-power state
// R10 - pin falling while synced fades playback to mid level over 2100
// R11 - record output goes zero when internal reset asserts
// R12 - pin high again repeats the full power-on sequence
// R13 - pin toggle during a fade reverses fade direction at once
// R14 - host changes pins and clocks only in power-down mode
// R15 - record samples at 64 fs, decimates to 24 or 16-bit words
// R16 - record removes DC by high-pass, sends left/right serial words
// R17 - playback interpolates by eight into 8-level modulator at 64 fs
// R18 - drift beyond tolerance halts and mutes both paths until resync
// R19 - host supplies 64 or 48 bit clocks per frame
// R20 - ratio found by counting master cycles per frame period
module ccrs_sequencer (
  input wire core_clk,
  input wire sys_rst,
  input wire master_clock_in,
  input wire bit_clock,
  input wire frame_clock,
  input wire power_down_pin_n,
  input wire serial_data_in,
  input wire record_in_left,
  input wire record_in_right,
  input wire record_word_16,
  output reg [2:0] playback_out_left,
  output reg [2:0] playback_out_right,
  output reg record_data_out,
  output reg internal_reset,
  output reg clocks_synced,
  output reg power_down_state
);

  localparam ST_HOLD = 2'h0;
  localparam ST_COUNT = 2'h1;
  localparam ST_RUN = 2'h2;
  localparam ST_FADEOUT = 2'h3;

  // ----------------------------------------
  // pin synchronisers
  // ----------------------------------------
  wire [7:0] pins;
  reg [7:0] meta;
  reg [7:0] sync;
  reg [3:0] prev;
  assign pins = {record_word_16, record_in_right, record_in_left, serial_data_in,
                 power_down_pin_n, frame_clock, bit_clock, master_clock_in};

  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_sync
      always @(posedge core_clk) begin
        if (sys_rst) begin
          meta[g] <= 1'b0;
          sync[g] <= 1'b0;
        end else begin
          meta[g] <= pins[g];
          sync[g] <= meta[g];
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (sys_rst) begin
      prev <= 4'h0;
    end else begin
      prev <= sync[3:0];
    end
  end

  wire mclk_rise = sync[0] & ~prev[0];
  wire bclk_rise = sync[1] & ~prev[1];
  wire bclk_fall = ~sync[1] & prev[1];
  wire frame_rise = sync[2] & ~prev[2];
  wire frame_fall = ~sync[2] & prev[2];
  wire pin_n = sync[3];
  wire din = sync[4];
  wire [1:0] rec_bit = sync[6:5];
  wire word16 = sync[7];

  // ----------------------------------------
  // ratio detection and 64 fs tick
  // ----------------------------------------
  wire in_sync;
  wire ratio_low;
  wire [3:0] os_div;
  reg [3:0] os_cnt;
  reg os_tick;

  ccrs_ratio_detect ccrs_ratio_detect_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .mclk_rise(mclk_rise),
    .bclk_rise(bclk_rise),
    .frame_rise(frame_rise),
    .in_sync(in_sync),
    .ratio_low(ratio_low),
    .os_div(os_div)
  );

  // ticks at 64 fs whatever the ratio, since the divider follows it
  always @(posedge core_clk) begin
    if (sys_rst) begin
      os_cnt <= 4'h0;
      os_tick <= 1'b0;
    end else begin
      os_tick <= 1'b0;
      if (frame_rise) begin
        os_cnt <= 4'h0;
      end else if (mclk_rise) begin
        if (os_cnt + 4'h1 >= os_div) begin // R17 R15
          os_cnt <= 4'h0;
          os_tick <= 1'b1;
        end else begin
          os_cnt <= os_cnt + 4'h1;
        end
      end
    end
  end

  // ----------------------------------------
  // reset and power-down sequence
  // ----------------------------------------
  reg [1:0] state;
  reg [1:0] next_state;
  reg [10:0] rel_cnt;
  reg [12:0] adc_cnt;
  wire fade_up = (state == ST_RUN);
  wire [11:0] fade_level;
  wire fade_top;
  wire fade_zero;

  ccrs_fade ccrs_fade_inst (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .clear(state == ST_HOLD || state == ST_COUNT),
    .up(fade_up),
    .tick(frame_rise),
    .level(fade_level),
    .at_top(fade_top),
    .at_zero(fade_zero)
  );

  always @* begin
    next_state = state;
    case (state)
      ST_HOLD: begin
        if (pin_n && in_sync) begin // R7 R9
          next_state = ST_COUNT;
        end
      end
      ST_COUNT: begin
        if (!pin_n || !in_sync) begin // R7 R9
          next_state = ST_HOLD;
        end else if (rel_cnt == `CCRS_RELEASE_CYC) begin // R4 R12
          next_state = ST_RUN;
        end
      end
      ST_RUN: begin
        if (!in_sync) begin // R18 R7
          next_state = ST_HOLD;
        end else if (!pin_n) begin // R10
          next_state = ST_FADEOUT;
        end
      end
      ST_FADEOUT: begin
        if (!in_sync) begin // R18
          next_state = ST_HOLD;
        end else if (pin_n) begin // R13
          next_state = ST_RUN;
        end else if (fade_zero) begin // R10 R11
          next_state = ST_HOLD;
        end
      end
      default: begin
        next_state = ST_HOLD;
      end
    endcase
  end

  always @(posedge core_clk) begin
    if (sys_rst) begin
      state <= ST_HOLD;
      rel_cnt <= 11'h000;
      adc_cnt <= 13'h0000;
    end else begin
      state <= next_state;
      if (state != ST_COUNT) begin
        rel_cnt <= 11'h000;
      end else if (mclk_rise) begin
        rel_cnt <= rel_cnt + 11'h001; // R4
      end
      // record start-up restarts on every release, so a resync or a
      // second power-up waits the full initialisation again
      if (state == ST_HOLD || state == ST_COUNT) begin
        adc_cnt <= 13'h0000; // R8 R12
      end else if (frame_rise && adc_cnt != `CCRS_ADC_DLY) begin
        adc_cnt <= adc_cnt + 13'h0001; // R6
      end
    end
  end

  wire running = (state == ST_RUN) || (state == ST_FADEOUT);
  wire record_live = running && (adc_cnt == `CCRS_ADC_DLY) && !ratio_low; // R6 R3 R2

  // ----------------------------------------
  // record and playback paths: decimation, high-pass, interpolation, modulator
  // ----------------------------------------
  reg [6:0] ones [0:1];
  reg signed [23:0] dc [0:1];
  reg signed [23:0] rec_word [0:1];
  reg signed [23:0] tgt [0:1];
  reg signed [23:0] interp [0:1];
  reg [24:0] sum [0:1];
  reg [20:0] err [0:1];
  reg [2:0] level [0:1];
  reg [2:0] step_cnt;

  generate
    for (g = 0; g < 2; g = g + 1) begin : g_chan
      wire signed [23:0] raw = {ones[g] - `CCRS_OS_HALF, 17'h00000};
      wire signed [23:0] hp = raw - dc[g];
      wire signed [36:0] prod = interp[g] * $signed({1'b0, fade_level});
      wire signed [23:0] scaled = fade_top ? interp[g] : prod[`CCRS_GAIN_SHIFT +: 24];
      wire [24:0] acc = {1'b0, ~scaled[23], scaled[22:0]} + {4'h0, err[g]};

      always @(posedge core_clk) begin
        if (sys_rst || !running) begin
          ones[g] <= 7'h00;
          dc[g] <= 24'h000000;
          rec_word[g] <= 24'h000000;
          interp[g] <= 24'h000000;
          err[g] <= 21'h000000;
          level[g] <= `CCRS_MID_LEVEL;
        end else begin
          // one modulator bit per 64 fs tick, one word per frame
          if (frame_rise) begin
            ones[g] <= {6'h00, os_tick & rec_bit[g]}; // R15
            dc[g] <= dc[g] + (hp >>> `CCRS_HPF_SHIFT); // R16
            rec_word[g] <= word16 ? {hp[23:8], 8'h00} : hp; // R15 R16
          end else if (os_tick && rec_bit[g]) begin
            ones[g] <= ones[g] + 7'h01; // R15
          end
          if (os_tick) begin
            // first-order 8-level noise shaper at 64 fs
            if (acc[24]) begin
              level[g] <= 3'h7;
              err[g] <= 21'h1FFFFF;
            end else begin
              level[g] <= acc[23:21]; // R17
              err[g] <= acc[20:0];
            end
            if (step_cnt == 3'h7) begin
              interp[g] <= interp[g] + ((tgt[g] - interp[g]) >>> `CCRS_INTERP_SHIFT); // R17
            end
          end
        end
      end
    end
  endgenerate

  always @(posedge core_clk) begin
    if (sys_rst || !running) begin
      step_cnt <= 3'h0;
    end else if (os_tick) begin
      step_cnt <= step_cnt + 3'h1;
    end
  end

  // ----------------------------------------
  // serial ports
  // ----------------------------------------
  reg [23:0] din_sh;
  reg [23:0] dout_sh;

  always @(posedge core_clk) begin
    if (sys_rst) begin
      din_sh <= 24'h000000;
      dout_sh <= 24'h000000;
      tgt[0] <= 24'h000000;
      tgt[1] <= 24'h000000;
    end else begin
      if (bclk_rise) begin
        din_sh <= {din_sh[22:0], din};
      end
      // frame high carries left; the word ends at the frame edge
      if (frame_fall) begin
        tgt[0] <= din_sh;
      end
      if (frame_rise) begin
        tgt[1] <= din_sh;
      end
      if (!record_live) begin
        dout_sh <= 24'h000000; // R11 R3
      end else if (frame_rise) begin
        dout_sh <= rec_word[0]; // R16
      end else if (frame_fall) begin
        dout_sh <= rec_word[1]; // R16
      end else if (bclk_fall) begin
        dout_sh <= {dout_sh[22:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always @(posedge core_clk) begin
    if (sys_rst) begin
      playback_out_left <= `CCRS_MID_LEVEL;
      playback_out_right <= `CCRS_MID_LEVEL;
      record_data_out <= 1'b0;
      internal_reset <= 1'b1;
      clocks_synced <= 1'b0;
      power_down_state <= 1'b1;
    end else begin
      playback_out_left <= running ? level[0] : `CCRS_MID_LEVEL; // R5 R10 R18
      playback_out_right <= running ? level[1] : `CCRS_MID_LEVEL; // R5 R10 R18
      record_data_out <= record_live & dout_sh[23]; // R11 R3 R6
      internal_reset <= !running; // R7 R9 R11
      clocks_synced <= in_sync;
      power_down_state <= (state == ST_HOLD); // R9 R7
    end
  end

endmodule
`default_nettype wire

// *** ccrs_seq_asserts.sv ***
// Purpose: port checks for the codec clock and reset sequencer
// Assumes: master clock runs below a quarter of core_clk
// Notes: helper counts carry a few counts of slack for the pin synchronisers
`timescale 1ns/1ps
`default_nettype none
module ccrs_seq_asserts (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic master_clock_in,
  input wire logic frame_clock,
  input wire logic power_down_pin_n,
  input wire logic [2:0] playback_out_left,
  input wire logic [2:0] playback_out_right,
  input wire logic record_data_out,
  input wire logic internal_reset,
  input wire logic clocks_synced,
  input wire logic power_down_state
);
  // ----------------------------------------
  // helper counts
  // ----------------------------------------
  logic [11:0] mrise_cnt;
  logic [12:0] frame_cnt;
  logic [11:0] gap_cnt;
  always @(posedge core_clk) begin
    if (sys_rst || power_down_state || !internal_reset) begin
      mrise_cnt <= 12'h000;
    end else if ($rose(master_clock_in) && mrise_cnt != 12'hFFF) begin
      mrise_cnt <= mrise_cnt + 12'h001;
    end
    if (sys_rst || internal_reset) begin
      frame_cnt <= 13'h0000;
    end else if ($rose(frame_clock) && frame_cnt != 13'h1FFF) begin
      frame_cnt <= frame_cnt + 13'h0001;
    end
    if (sys_rst || $rose(frame_clock)) begin
      gap_cnt <= 12'h000;
    end else if ($rose(master_clock_in) && gap_cnt != 12'hFFF) begin
      gap_cnt <= gap_cnt + 12'h001;
    end
  end
  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  reset_state_a: assert property ($fell(sys_rst) |-> internal_reset && power_down_state && !clocks_synced)
    else $error("state after reset wrong");
  release_count_a: assert property ($fell(internal_reset) |-> mrise_cnt >= 12'd1021 && mrise_cnt <= 12'd1028)
    else $error("release count wrong");
  mute_in_reset_a: assert property (internal_reset && $past(internal_reset) |-> !record_data_out)
    else $error("record data live in reset");
  hold_mid_a: assert property (power_down_state && $past(power_down_state) |->
    playback_out_left == 3'h4 && playback_out_right == 3'h4)
    else $error("playback not mid in power-down");
  hold_unsynced_a: assert property (!clocks_synced [*8] |-> internal_reset && power_down_state)
    else $error("running without lock");
  release_needs_pin_a: assert property ($fell(internal_reset) |-> $past(power_down_pin_n, 4) && clocks_synced)
    else $error("release with pin low");
  hold_pin_a: assert property (power_down_state && $past(power_down_pin_n, 3) == 1'b0 |=> power_down_state)
    else $error("left power-down with pin low");
  no_early_live_a: assert property (record_data_out |-> frame_cnt >= 13'd4497)
    else $error("record data too early");
  frame_watch_a: assert property (clocks_synced |-> gap_cnt <= 12'd2052)
    else $error("lock kept without frames");
  cover property ($fell(internal_reset));
  cover property ($rose(power_down_state) && !power_down_pin_n);
  cover property ($fell(clocks_synced));
endmodule
bind ccrs_sequencer ccrs_seq_asserts ccrs_seq_asserts_inst (
  .core_clk(core_clk),
  .sys_rst(sys_rst),
  .master_clock_in(master_clock_in),
  .frame_clock(frame_clock),
  .power_down_pin_n(power_down_pin_n),
  .playback_out_left(playback_out_left),
  .playback_out_right(playback_out_right),
  .record_data_out(record_data_out),
  .internal_reset(internal_reset),
  .clocks_synced(clocks_synced),
  .power_down_state(power_down_state)
);
`default_nettype wire

// *** ccrs_host_model.sv ***
// Purpose: audio host driving master, bit and frame clocks and the power-down pin
// Assumes: master clock of 20 MHz, below a quarter of core_clk
// Notes: clocks stand still while run is low
`timescale 1ns/1ps
`default_nettype none
module ccrs_host_model (
  input wire logic run,
  input wire logic [10:0] ratio,
  input wire logic [3:0] per_bit,
  input wire logic pin_req_n,
  output logic master_clock_in,
  output logic bit_clock,
  output logic frame_clock,
  output logic serial_data_in,
  output wire logic power_down_pin_n
);
  int mcnt = 0;
  assign power_down_pin_n = pin_req_n;
  // ----------------------------------------
  // clock generation
  // ----------------------------------------
  // bit and frame edges follow master rises, so the three stay locked;
  // the 2 ns start offset keeps every pin edge off the core_clk grid
  initial begin
    master_clock_in = 1'b0;
    bit_clock = 1'b0;
    frame_clock = 1'b1;
    serial_data_in = 1'b0;
    #2;
    forever begin
      #25;
      if (run) begin
        master_clock_in = ~master_clock_in;
        if (master_clock_in) begin
          mcnt = (mcnt + 1) % ratio;
          frame_clock = mcnt < ratio / 2;
          bit_clock = (mcnt % per_bit) >= per_bit / 2;
          serial_data_in = mcnt[4] ^ mcnt[1];
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** ccrs_sequencer_tb_top.sv ***
// Purpose: self-checking bench for the codec clock and reset sequencer
// Assumes: 20 MHz master clock, 256 master cycles per frame unless changed
// Notes: the full fade and record delays are too long to run out here
`timescale 1ns/1ps
`default_nettype none
module ccrs_sequencer_tb_top;
  localparam int FRAME = 1280;
  logic core_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic run = 1'b0;
  logic [10:0] ratio = 11'd256;
  logic [3:0] per_bit = 4'd4;
  logic pin_req_n = 1'b1;
  logic rec_l = 1'b0;
  logic word_16 = 1'b0;
  logic mclk, bclk, fclk, sdin, pdn_n, rec_out, int_rst, synced, pd_state;
  logic [2:0] out_l, out_r;
  int n_fail = 0;
  int n_checks = 0;
  int cyc;
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) rec_l <= #1 ~rec_l;
  ccrs_host_model ccrs_host_model_inst (.run(run), .ratio(ratio), .per_bit(per_bit), .pin_req_n(pin_req_n),
    .master_clock_in(mclk), .bit_clock(bclk), .frame_clock(fclk), .serial_data_in(sdin), .power_down_pin_n(pdn_n));
  ccrs_sequencer ccrs_sequencer_inst (.core_clk(core_clk), .sys_rst(sys_rst), .master_clock_in(mclk),
    .bit_clock(bclk), .frame_clock(fclk), .power_down_pin_n(pdn_n), .serial_data_in(sdin),
    .record_in_left(rec_l), .record_in_right(~rec_l), .record_word_16(word_16),
    .playback_out_left(out_l), .playback_out_right(out_r), .record_data_out(rec_out),
    .internal_reset(int_rst), .clocks_synced(synced), .power_down_state(pd_state));
  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  // status bit 0 lock, 1 internal reset, 2 power-down; cyc holds the wait
  task automatic wait_bit(input int idx, input logic val, input int lim);
    logic [2:0] st;
    cyc = 0;
    st = {pd_state, int_rst, synced};
    while (st[idx] !== val && cyc < lim) begin
      tick(1);
      cyc++;
      st = {pd_state, int_rst, synced};
    end
  endtask
  task automatic t_startup;
    run = 1'b1;
    wait_bit(0, 1'b1, 6 * FRAME);
    check("lock", synced, 1'b1);
    check("held", int_rst, 1'b1);
    wait_bit(1, 1'b0, 6000);
    check("release_time", cyc > 5050 && cyc < 5150, 1'b1);
    tick(3 * FRAME);
    check("rec_quiet", rec_out, 1'b0);
  endtask
  // level is about 13 at the first fall; four frames down and four back up return it there
  task automatic t_fade_turn;
    tick(10 * FRAME);
    pin_req_n = 1'b0;
    tick(4 * FRAME);
    check("fading", int_rst, 1'b0);
    pin_req_n = 1'b1;
    tick(4 * FRAME);
    pin_req_n = 1'b0;
    wait_bit(2, 1'b1, 20 * FRAME);
    check("fade_back", cyc > 11 * FRAME && cyc < 16 * FRAME, 1'b1);
    check("rst_on", int_rst, 1'b1);
    check("rec_zero", rec_out, 1'b0);
    tick(2);
    check("mid_l", out_l, 3'h4);
    check("mid_r", out_r, 3'h4);
  endtask
  task automatic t_repower;
    tick(3 * FRAME);
    check("pd_stays", pd_state, 1'b1);
    word_16 = 1'b1;
    pin_req_n = 1'b1;
    wait_bit(1, 1'b0, 8000);
    check("repeat_count", cyc > 5050 && cyc < 5300, 1'b1);
  endtask
  task automatic t_lost_sync;
    tick(2 * FRAME);
    ratio = 11'd320;
    per_bit = 4'd5;
    wait_bit(0, 1'b0, 8 * 1600);
    check("drop", cyc < 6 * 1600 + 100, 1'b1);
    tick(3 * 1600);
    check("kept_rst", int_rst, 1'b1);
    check("kept_pd", pd_state, 1'b1);
    check("rec_mute", rec_out, 1'b0);
    // come back at 192 fs with 48 bit clocks per frame: record must stay off
    ratio = 11'd192;
    per_bit = 4'd4;
    wait_bit(0, 1'b1, 8 * FRAME);
    check("relock_48", synced, 1'b1);
    wait_bit(1, 1'b0, 6000);
    check("resume", cyc > 5050 && cyc < 5150, 1'b1);
    tick(2 * FRAME);
    check("rec_low", rec_out, 1'b0);
  endtask
  task automatic tally_and_finish;
    if (n_fail == 0 && n_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    tick(10);
    sys_rst = 1'b0;
    tick(1);
    check("rst_vals", {int_rst, pd_state, synced}, 3'h6);
    t_startup();
    t_fade_turn();
    t_repower();
    t_lost_sync();
    tally_and_finish();
  end
  initial begin
    #950000;
    n_fail++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
